// ---- relay_out_pkg.sv ----
// Shared constants and carriers for the relay output channel controller
package relay_out_pkg;
    localparam int          CLK_HZ         = 100_000_000;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          RELAY_RESP_MS  = 20;
    localparam int          RELAY_SETTLE_CYC = RELAY_RESP_MS * (CLK_HZ / 1000);
    localparam int          WDOG_TIMEOUT_MS = 2000;
    localparam longint      WDOG_CYC       = longint'(WDOG_TIMEOUT_MS) * (CLK_HZ / 1000);
    localparam int          BLINK_HALF_MS  = 250;
    localparam int          BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int          INV_BIT        = 1;
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    localparam int          BYTES_4CH      = 1;
    localparam int          BYTES_8CH      = 2;

    typedef enum logic [1:0] {
        XFER_OUTPUT = 2'b00,
        XFER_CONFIG = 2'b01,
        XFER_VALID  = 2'b10
    } xfer_kind_e;

    typedef struct packed {
        logic [7:0] data;
        logic [2:0] index;
        xfer_kind_e kind;
        logic       last;
    } xfer_s;
endpackage : relay_out_pkg

// ---- status_led_ctrl.sv ----
// Front status indicator driver: power/fuse green, link red with blink
module status_led_ctrl #(
    parameter int BLINK_CYC = relay_out_pkg::BLINK_HALF_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic auxPowerOk,
    input  wire logic fuseOk,
    input  wire logic linkUp,
    output logic      greenLed,
    output logic      redLed
);
    typedef struct packed {
        logic [31:0] blinkCnt;
        logic        phase;
        logic        green;
        logic        red;
    } led_state_s;

    led_state_s st_r;
    led_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.green = auxPowerOk && fuseOk;
        if (st_r.blinkCnt >= 32'(BLINK_CYC - 1)) begin
            st_nxt.blinkCnt = '0;
            st_nxt.phase    = ~st_r.phase;
        end else begin
            st_nxt.blinkCnt = st_r.blinkCnt + 32'd1;
        end
        // Steady lit while talking, blinking while the link is lost
        st_nxt.red = linkUp ? 1'b1 : st_r.phase;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign greenLed = st_r.green;
    assign redLed   = st_r.red;

    AST_GREEN_FOLLOWS: assert property (@(posedge clk) disable iff (!rstn)
        ##1 greenLed == $past(auxPowerOk && fuseOk))
        else $error("green indicator does not follow power and fuse");
    AST_RED_STEADY_LINK: assert property (@(posedge clk) disable iff (!rstn)
        linkUp |=> redLed)
        else $error("red indicator not steady while link up");
endmodule : status_led_ctrl

// ---- relay_output_channel_ctrl.sv ----
// Relay output channel controller: block data intake, config, watchdog, LEDs
// What this block does
// - Four or eight normally open relay channels
// - Contact reaches commanded state within 20 ms
// - Four-channel variant takes one output byte
// - Eight-channel variant takes two output bytes
// - Transfer sets relays or validates settings
// - Flag error on empty or wrong slot
// - Watchdog zeroes outputs after 2 s silence
// - Red indicator blinks while link is down
// - Green lit only with power and fuse
// - Hold outputs during hot reconfiguration unless the watchdog has expired
// - Configuration stored separately per channel
// - Config bit 1 is the inverter enable
// - Inverter selects positive or negative logic
module relay_output_channel_ctrl #(
    parameter int     NUM_CH    = 8,
    parameter longint WDOG_CYC  = relay_out_pkg::WDOG_CYC,
    parameter int     BLINK_CYC = relay_out_pkg::BLINK_HALF_CYC,
    parameter logic [7:0] EXPECTED_MODULE_ID = 8'h5a // Arbitrary value
) (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  xferValid,
    input  wire relay_out_pkg::xfer_s  xfer,
    input  wire logic                  hotReconfigInRun,
    input  wire logic                  slotOccupied,
    input  wire logic [7:0]            slotModuleId,
    input  wire logic                  auxPowerOk,
    input  wire logic                  fuseOk,
    output logic [NUM_CH-1:0]          relayDrive,
    output logic [NUM_CH-1:0]          commandState,
    output logic [NUM_CH*8-1:0]        channelConfig,
    output logic                       configValid,
    output logic                       deviceError,
    output logic                       watchdogExpired,
    output logic                       greenLed,
    output logic                       redLed
);
    localparam int NBYTES = (NUM_CH > 4) ? relay_out_pkg::BYTES_8CH : relay_out_pkg::BYTES_4CH;

    // Pin vector order: hot reconfig, slot occupied, aux power, fuse, module id
    localparam int NPINS = 12;

    typedef struct packed {
        logic [NUM_CH-1:0]          cmd;
        logic [7:0]                 lowByte;
        logic [NUM_CH*8-1:0]        cfg;
        logic                       cfgValid;
        logic                       byteIdx;
        logic [NUM_CH-1:0]          drive;
        logic [63:0]                wdogCnt;
        logic                       expired;
        logic                       devErr;
        logic [2:0][NPINS-1:0]      pinSync;
        logic [NPINS-1:0]           pinVal;
    } core_state_s;

    core_state_s st_r;
    core_state_s st_nxt;

    // Inverter bit of one channel's configuration byte
    function automatic logic invOf(input logic [NUM_CH*8-1:0] cfg, input int ch);
        invOf = cfg[ch*8 + relay_out_pkg::INV_BIT];
    endfunction : invOf

    // Inverter bits of all channels as one mask
    function automatic logic [NUM_CH-1:0] invMask(input logic [NUM_CH*8-1:0] cfg);
        invMask = '0;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            invMask[ch] = invOf(cfg, ch);
        end
    endfunction : invMask

    logic        hcirHeld;
    logic        occFilt;
    logic        pwrFilt;
    logic        fuseFilt;
    logic [7:0]  idFilt;
    logic [15:0] outWord;

    // Filtered pin levels; a bit moves only once two sync stages agree
    assign hcirHeld = st_r.pinVal[11];
    assign occFilt  = st_r.pinVal[10];
    assign pwrFilt  = st_r.pinVal[9];
    assign fuseFilt = st_r.pinVal[8];
    assign idFilt   = st_r.pinVal[7:0];

    always_comb begin
        st_nxt  = st_r;
        outWord = '0;
        // Pins arrive from outside the clock domain
        st_nxt.pinSync = {st_r.pinSync[1:0],
                          {hotReconfigInRun, slotOccupied, auxPowerOk, fuseOk, slotModuleId}};
        for (int b = 0; b < NPINS; b++) begin
            if (st_r.pinSync[2][b] == st_r.pinSync[1][b]) begin
                st_nxt.pinVal[b] = st_r.pinSync[2][b];
            end
        end
        // Module id bits are filtered one by one; a slot swap settles in a few cycles
        st_nxt.devErr = !occFilt || (idFilt != EXPECTED_MODULE_ID);

        if (st_r.expired) begin
            st_nxt.wdogCnt = st_r.wdogCnt;
        end else if (st_r.wdogCnt >= 64'(WDOG_CYC - 1)) begin
            st_nxt.expired = 1'b1;
        end else begin
            st_nxt.wdogCnt = st_r.wdogCnt + 64'd1;
        end

        if (xferValid) begin
            st_nxt.wdogCnt = '0;
            st_nxt.expired = 1'b0;
            case (xfer.kind)
                relay_out_pkg::XFER_OUTPUT: begin
                    // Bytes assemble in a shadow; applied only once the block is whole
                    if (NBYTES == 1 || xfer.last || st_r.byteIdx) begin
                        if (NBYTES == 1 || !st_r.byteIdx) begin
                            outWord = {8'h00, xfer.data};
                        end else begin
                            outWord = {xfer.data, st_r.lowByte};
                        end
                        st_nxt.cmd     = outWord[NUM_CH-1:0];
                        st_nxt.byteIdx = 1'b0;
                    end else begin
                        // First of two bytes is parked, relays untouched yet
                        st_nxt.lowByte = xfer.data;
                        st_nxt.byteIdx = 1'b1;
                    end
                end
                relay_out_pkg::XFER_CONFIG: begin
                    if (32'(xfer.index) < NUM_CH) begin
                        st_nxt.cfg[xfer.index*8 +: 8] = xfer.data;
                        st_nxt.cfgValid = 1'b0;
                    end
                end
                relay_out_pkg::XFER_VALID: begin
                    st_nxt.cfgValid = 1'b1;
                end
                default: begin
                    st_nxt.byteIdx = st_r.byteIdx;
                end
            endcase
        end

        // Drive registers the command xor the inverter mask; the relay settles in well under 20 ms
        if (st_r.expired) begin
            st_nxt.drive = '0;
        end else if (!hcirHeld) begin
            st_nxt.drive = st_r.cmd ^ invMask(st_r.cfg);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r     <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    status_led_ctrl #(
        .BLINK_CYC (BLINK_CYC)
    ) u_leds (
        .clk        (clk),
        .rstn       (rstn),
        .auxPowerOk (pwrFilt),
        .fuseOk     (fuseFilt),
        .linkUp     (!st_r.expired),
        .greenLed   (greenLed),
        .redLed     (redLed)
    );

    assign relayDrive      = st_r.drive;
    assign commandState    = st_r.cmd;
    assign channelConfig   = st_r.cfg;
    assign configValid     = st_r.cfgValid;
    assign deviceError     = st_r.devErr;
    assign watchdogExpired = st_r.expired;

    sequence s_expired;
        watchdogExpired;
    endsequence
    sequence s_zeroed;
        ##1 relayDrive == '0;
    endsequence

    AST_WDOG_ZERO: assert property (@(posedge clk) disable iff (!rstn)
        s_expired |-> s_zeroed)
        else $error("outputs not zero after watchdog expiry");
    AST_WDOG_CLEARS: assert property (@(posedge clk) disable iff (!rstn)
        xferValid |=> !watchdogExpired)
        else $error("valid traffic did not clear watchdog");
    AST_DRIVE_XOR: assert property (@(posedge clk) disable iff (!rstn)
        (!watchdogExpired && !hcirHeld) |=>
            relayDrive == ($past(commandState) ^ invMask($past(channelConfig))))
        else $error("relay drive not command xor inverter");
    AST_HOT_RECONFIG_IN_RUN_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        (hcirHeld && !watchdogExpired) |=> $stable(relayDrive))
        else $error("outputs changed during hot reconfiguration");
    AST_DEV_ERR: assert property (@(posedge clk) disable iff (!rstn)
        !occFilt |=> deviceError)
        else $error("missing module not flagged");
    AST_VALID_MARK: assert property (@(posedge clk) disable iff (!rstn)
        (xferValid && xfer.kind == relay_out_pkg::XFER_VALID) |=> configValid)
        else $error("settings not marked valid");
    AST_CFG_STORE: assert property (@(posedge clk) disable iff (!rstn)
        (xferValid && xfer.kind == relay_out_pkg::XFER_CONFIG && 32'(xfer.index) < NUM_CH)
            |=> channelConfig[$past(xfer.index)*8 +: 8] == $past(xfer.data))
        else $error("channel config byte not stored");
    AST_ONE_BYTE: assert property (@(posedge clk) disable iff (!rstn)
        (NBYTES == 1 && xferValid && xfer.kind == relay_out_pkg::XFER_OUTPUT)
            |=> commandState == NUM_CH'($past(xfer.data)))
        else $error("single output byte not applied");
    AST_SETTLE: assert property (@(posedge clk) disable iff (!rstn)
        $changed(commandState) && !watchdogExpired && !hcirHeld
            |-> ##[1:2] (relayDrive[0] == (commandState[0] ^ channelConfig[relay_out_pkg::INV_BIT])
                || hcirHeld || watchdogExpired))
        else $error("relay drive did not follow command in time");
endmodule : relay_output_channel_ctrl

// ---- bus_gateway_unit.sv ----
// Behavioural gateway unit that sends block transfer words to the relay controller
module bus_gateway_unit (
    input  wire logic             clk,
    output logic                  xferValid,
    output relay_out_pkg::xfer_s  xfer
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        xferValid = 1'b0;
        xfer = '0;
    end

    // One pulse per word; payload scrambled once released so stale data never looks valid
    task automatic send(input relay_out_pkg::xfer_kind_e kind, input logic [2:0] index,
                        input logic [7:0] data, input logic last);
        @(posedge clk);
        xferValid <= 1'b1;
        xfer <= '{data: data, index: index, kind: kind, last: last};
        @(posedge clk);
        xferValid <= 1'b0;
        xfer <= relay_out_pkg::xfer_s'(~xfer);
    endtask : send
endmodule : bus_gateway_unit

// ---- tb.sv ----
// Self-checking bench for the relay output channel controller
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam longint WDOG = 1000;
    logic                 clk, rstn, hot, occ, pwr, fuse, xferValid, devErr, wdExp;
    logic                 cfgOk, green, red, prev;
    logic [7:0]           modId, drive, cmd;
    logic [63:0]          cfg;
    relay_out_pkg::xfer_s xfer;
    int                   num_errors = 0;
    int                   checked = 0;
    int                   toggles;

    bus_gateway_unit i_bus_gateway_unit (.clk(clk), .xferValid(xferValid), .xfer(xfer));
    relay_output_channel_ctrl #(.NUM_CH(8), .WDOG_CYC(WDOG), .BLINK_CYC(10))
        i_relay_output_channel_ctrl (.clk(clk), .rstn(rstn), .xferValid(xferValid),
        .xfer(xfer), .hotReconfigInRun(hot), .slotOccupied(occ), .slotModuleId(modId),
        .auxPowerOk(pwr), .fuseOk(fuse), .relayDrive(drive), .commandState(cmd),
        .channelConfig(cfg), .configValid(cfgOk), .deviceError(devErr),
        .watchdogExpired(wdExp), .greenLed(green), .redLed(red));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    task automatic out(input logic [7:0] data, input logic [7:0] exp);
        i_bus_gateway_unit.send(relay_out_pkg::XFER_OUTPUT, 3'd0, data, 1'b1);
        idle(3);
        chk(cmd, data);
        chk(drive, exp);
    endtask : out

    task automatic env(input logic o, input logic [7:0] id, input logic p, input logic f);
        @(posedge clk);
        occ <= o;
        modId <= id;
        pwr <= p;
        fuse <= f;
        idle(6);
        chk(devErr, !o || id != 8'h5a);
        chk(green, p && f);
    endtask : env

    task automatic give_verdict();
        $display("errors=%0d checks=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #100us;
        num_errors++;
        give_verdict();
    end

    initial begin
        rstn = 1'b0;
        {hot, occ, pwr, fuse} = 4'h7;
        modId = 8'h5a;
        idle(12);
        chk({drive, cmd, cfgOk, devErr, wdExp, green, red}, 64'h0);
        chk(cfg, {8{relay_out_pkg::CFG_RESET}});
        @(posedge clk);
        rstn <= 1'b1;
        i_bus_gateway_unit.send(relay_out_pkg::XFER_CONFIG, 3'd1, 8'h02, 1'b1);
        i_bus_gateway_unit.send(relay_out_pkg::XFER_CONFIG, 3'd5, 8'hfd, 1'b1);
        idle(3);
        chk(cfg, 64'h0000_fd00_0000_0200);
        chk(cfgOk, 1'b0);
        i_bus_gateway_unit.send(relay_out_pkg::XFER_VALID, 3'd0, 8'h00, 1'b1);
        idle(3);
        chk(cfgOk, 1'b1);
        out(8'ha5, 8'ha7);
        out(8'hff, 8'hfd);
        i_bus_gateway_unit.send(relay_out_pkg::XFER_OUTPUT, 3'd0, 8'h81, 1'b0);
        chk(cmd, 8'hff);
        i_bus_gateway_unit.send(relay_out_pkg::XFER_OUTPUT, 3'd0, 8'h7e, 1'b1);
        idle(3);
        chk(cmd, 8'h81);
        chk(drive, 8'h83);
        // Frozen drive must survive a new command until the sync chain releases
        @(posedge clk);
        hot <= 1'b1;
        idle(5);
        i_bus_gateway_unit.send(relay_out_pkg::XFER_OUTPUT, 3'd0, 8'h3c, 1'b1);
        idle(3);
        chk(drive, 8'h83);
        @(posedge clk);
        hot <= 1'b0;
        idle(8);
        chk(drive, 8'h3e);
        env(1'b0, 8'h5a, 1'b1, 1'b0);
        env(1'b1, 8'ha5, 1'b0, 1'b1);
        env(1'b1, 8'h5a, 1'b0, 1'b0);
        env(1'b1, 8'h5a, 1'b1, 1'b1);
        idle(900);
        chk(wdExp, 1'b0);
        idle(150);
        chk(wdExp, 1'b1);
        chk(drive, 8'h00);
        toggles = 0;
        repeat (40) begin
            prev = red;
            idle(1);
            if (red !== prev) toggles++;
        end
        chk(toggles >= 3, 1'b1);
        out(8'h0f, 8'h0d);
        chk({wdExp, red}, 2'b01);
        give_verdict();
    end
endmodule : tb
